// *** owrpr_pkg.sv ***
// Purpose: Shared constants for the single-wire RGB dimming receiver.
// Assumes: System clock of 125 MHz; all counts are in system clock cycles unless named.
// Notes:   Gamma turn-off counts are three linear segments joined end to end.
package owrpr_pkg;

    // System clock and the internal grayscale reference clock.
    localparam int CLK_PERIOD_NS     = 8;
    localparam int CLK_HZ            = 125_000_000;
    localparam int GRAYSCALE_REF_CLOCK_HZ          = 6_000_000;
    localparam int GRAYSCALE_REF_CLOCK_DIV         = CLK_HZ / GRAYSCALE_REF_CLOCK_HZ;

    // Bit period limits the host must keep; the measured value saturates at the top.
    localparam int BIT_PERIOD_MIN_NS = 1660;
    localparam int BIT_PERIOD_MAX_NS = 50000;
    localparam int BIT_PERIOD_MIN_CYC = (BIT_PERIOD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BIT_PERIOD_MAX_CYC = BIT_PERIOD_MAX_NS / CLK_PERIOD_NS;

    // Gap lengths on the serial line in multiples of the measured bit period.
    localparam int PACKET_END_HOLD_PERIODS = 4;
    localparam int LATCH_HOLD_PERIODS      = 8;

    // Packet layout.
    localparam int          PACKET_BITS        = 32;
    localparam int          LEVEL_BITS         = 8;
    localparam int          CMD_LSB            = 24;
    localparam int          CH0_LSB            = 16;
    localparam int          CH1_LSB            = 8;
    localparam int          CH2_LSB            = 0;
    localparam logic [7:0]  WRITE_COMMAND_BYTE = 8'h3A;
    localparam logic [23:0] LATCH_RESET        = 24'h000000;
    localparam logic [31:0] SHIFT_RESET        = 32'h00000000;

    // Grayscale period length in reference clocks.
    localparam int PWM_PERIOD_GSCLKS = 1904;
    localparam int FINE_W            = 11;

    // Gamma segments: slope 2 up to code 7, slope 4 up to 31, slope 8 above.
    localparam logic [7:0]  GAMMA_KNEE_A = 8'h07;
    localparam logic [7:0]  GAMMA_KNEE_B = 8'h1F;
    localparam logic [10:0] GAMMA_BASE_A = 11'h00E;
    localparam logic [10:0] GAMMA_BASE_B = 11'h06E;

    // Receiver states.
    typedef enum logic [1:0] {
        RX_WAIT_FIRST = 2'b00,
        RX_MEASURE    = 2'b01,
        RX_SLOT       = 2'b10,
        RX_FORWARD    = 2'b11
    } owrpr_rx_state_t;

endpackage : owrpr_pkg

// *** owrpr_sync.sv ***
// Purpose: Two-stage synchroniser for the serial input pin.
// Assumes: The input is asynchronous to clk.
// Notes:   Only the second stage leaves this module.
`timescale 1ns/10ps
module owrpr_sync (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    input  wire logic asyncIn,
    output logic      syncOut
);
    logic stageOne;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stageOne <= 1'b0;
            syncOut  <= 1'b0;
        end else if (ce) begin
            stageOne <= asyncIn;
            syncOut  <= stageOne;
        end
    end
endmodule : owrpr_sync

// *** owrpr_channel.sv ***
// Purpose: One grayscale output with its on/off decision registered.
// Assumes: Counter and done flag come from the shared grayscale timebase.
// Notes:   A level of zero keeps the output off for the whole period.
`timescale 1ns/10ps
module owrpr_channel
    import owrpr_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  ce,
    input  wire logic                  forceOff,
    input  wire logic [LEVEL_BITS-1:0] level,
    input  wire logic [LEVEL_BITS-1:0] grayCount,
    input  wire logic                  periodDone,
    output logic                       pwmOut
);
    logic onNow;

    assign onNow = (level != 8'h00) && (grayCount != 8'h00) &&
                   (grayCount <= level) && !periodDone;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pwmOut <= 1'b0;
        end else if (ce) begin
            if (forceOff) begin
                pwmOut <= 1'b0;
            end else begin
                pwmOut <= onNow;
            end
        end
    end
endmodule : owrpr_channel

// *** owrpr_top.sv ***
// Purpose: Single-wire receiver, packet forwarding and gamma-corrected grayscale PWM.
// Assumes: Host keeps the bit period limits and sends packets most significant bit first.
// Notes:   The grayscale reference clock is derived from clk by a divider.
//
// Overview of operation
// - Hold an 8-bit level for each of the three outputs.
// - Grayscale counter advances on the grayscale reference clock.
// - At count one all outputs turn on, except those with level zero.
// - An output stays on while count is at or below its level.
// - Loading the latch clears the counter and forces all outputs off.
// - On-time follows a gamma curve: codes 1, 7, 255 end at 2, 14, 1902.
// - After power-on outputs stay off until non-zero data is latched.
// - Measure first two rising edges after power-up or latch as the bit period.
// - The measurement shifts two zero bits into the shift register.
// - Second edge before half the bit period is a one, else a zero.
// - A packet-end low gap freezes the shift register and starts forwarding.
// - A longer latch low gap copies shift data into the latch.
// - Copy the low 24 bits only when the top byte is the write command.
// - Bits 0-7 feed output 2, 8-15 output 1, 16-23 output 0.
`timescale 1ns/10ps
module owrpr_top
    import owrpr_pkg::*;
#(
    parameter int MAX_PERIOD_CYCLES = BIT_PERIOD_MAX_CYC,
    parameter int END_HOLD_PERIODS  = PACKET_END_HOLD_PERIODS,
    parameter int LAT_HOLD_PERIODS  = LATCH_HOLD_PERIODS,
    parameter int GS_DIVIDE         = GRAYSCALE_REF_CLOCK_DIV,
    parameter int PERIOD_GSCLKS     = PWM_PERIOD_GSCLKS
) (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  ce,
    input  wire logic                  serialLineIn,
    output logic                       serialLineOut,
    output logic [2:0]                 pwmOut,
    output logic [LEVEL_BITS-1:0]      levelChannelZero,
    output logic [LEVEL_BITS-1:0]      levelChannelOne,
    output logic [LEVEL_BITS-1:0]      levelChannelTwo
);
    localparam int TIMER_W = 24;
    localparam int DIV_W   = 8;

    // Turn-off count of a grayscale code along the gamma curve.
    function automatic logic [FINE_W-1:0] gammaTurnOff(input logic [7:0] code);
        logic [FINE_W-1:0] wide;
        wide = {3'b000, code};
        if (code <= GAMMA_KNEE_A) begin
            gammaTurnOff = FINE_W'(wide << 1);
        end else if (code <= GAMMA_KNEE_B) begin
            gammaTurnOff = FINE_W'(GAMMA_BASE_A + ((wide - {3'b000, GAMMA_KNEE_A}) << 2));
        end else begin
            gammaTurnOff = FINE_W'(GAMMA_BASE_B + ((wide - {3'b000, GAMMA_KNEE_B}) << 3));
        end
    endfunction : gammaTurnOff

    owrpr_rx_state_t   rxState;
    logic              lineSync;
    logic              lineDelayed;
    logic              lineRise;
    logic [TIMER_W-1:0] slotTimer;
    logic [TIMER_W-1:0] lowCount;
    logic [TIMER_W-1:0] bitPeriod;
    logic [TIMER_W-1:0] halfPeriod;
    logic [TIMER_W-1:0] endThreshold;
    logic [TIMER_W-1:0] latchThreshold;
    logic              slotDecided;
    logic [PACKET_BITS-1:0] shiftReg;
    logic [23:0]       grayLatch;
    logic              latchEvent;
    logic              loadLatch;
    logic              endEvent;
    logic              decideOne;
    logic              decideZero;

    logic [DIV_W-1:0]  divCount;
    logic              gsTick;
    logic [FINE_W-1:0] fineCount;
    logic [7:0]        grayCount;
    logic              periodDone;
    logic [LEVEL_BITS-1:0] chLevel [3];

    owrpr_sync u_sync (
        .clk     (clk),
        .rst_n   (rst_n),
        .ce      (ce),
        .asyncIn (serialLineIn),
        .syncOut (lineSync)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lineDelayed <= 1'b0;
        end else if (ce) begin
            lineDelayed <= lineSync;
        end
    end

    assign lineRise = lineSync && !lineDelayed;

    assign halfPeriod     = bitPeriod >> 1;
    assign endThreshold   = TIMER_W'(bitPeriod * TIMER_W'(END_HOLD_PERIODS));
    assign latchThreshold = TIMER_W'(bitPeriod * TIMER_W'(LAT_HOLD_PERIODS));

    assign decideOne  = (rxState == RX_SLOT) && lineRise && !slotDecided &&
                        (slotTimer < halfPeriod);
    assign decideZero = (rxState == RX_SLOT) && !lineRise && !slotDecided &&
                        (slotTimer >= halfPeriod);

    assign endEvent   = (rxState == RX_SLOT) && !lineSync && (lowCount >= endThreshold);

    assign latchEvent = ((rxState == RX_SLOT) || (rxState == RX_FORWARD)) &&
                        !lineSync && (lowCount >= latchThreshold);

    assign loadLatch  = latchEvent &&
                        (shiftReg[PACKET_BITS-1:CMD_LSB] == WRITE_COMMAND_BYTE);

    // Time since the current slot started, saturating.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slotTimer <= '0;
        end else if (ce) begin
            if (lineRise && !decideOne) begin
                slotTimer <= '0;
            end else if (slotTimer != {TIMER_W{1'b1}}) begin
                slotTimer <= slotTimer + 1'b1;
            end
        end
    end

    // Length of the present low stretch on the line, saturating.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lowCount <= '0;
        end else if (ce) begin
            if (lineSync) begin
                lowCount <= '0;
            end else if (lowCount != {TIMER_W{1'b1}}) begin
                lowCount <= lowCount + 1'b1;
            end
        end
    end

    // Receiver sequence control.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rxState <= RX_WAIT_FIRST;
        end else if (ce) begin
            case (rxState)
                RX_WAIT_FIRST: begin
                    if (lineRise) begin
                        rxState <= RX_MEASURE;
                    end
                end
                RX_MEASURE: begin
                    if (lineRise) begin
                        rxState <= RX_SLOT;
                    end
                end
                RX_SLOT: begin
                    if (latchEvent) begin
                        rxState <= RX_WAIT_FIRST;
                    end else if (endEvent) begin
                        rxState <= RX_FORWARD;
                    end
                end
                RX_FORWARD: begin
                    if (latchEvent) begin
                        rxState <= RX_WAIT_FIRST;
                    end
                end
                default: begin
                    rxState <= RX_WAIT_FIRST;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bitPeriod <= TIMER_W'(MAX_PERIOD_CYCLES);
        end else if (ce) begin
            if ((rxState == RX_MEASURE) && lineRise) begin
                if (slotTimer > TIMER_W'(MAX_PERIOD_CYCLES)) begin
                    bitPeriod <= TIMER_W'(MAX_PERIOD_CYCLES);
                end else begin
                    bitPeriod <= slotTimer;
                end
            end
        end
    end

    // A slot is open until its bit has been decided.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slotDecided <= 1'b1;
        end else if (ce) begin
            if (rxState != RX_SLOT && !(rxState == RX_MEASURE && lineRise)) begin
                slotDecided <= 1'b1;
            end else if (decideOne || decideZero) begin
                slotDecided <= 1'b1;
            end else if (lineRise) begin
                slotDecided <= 1'b0;
            end
        end
    end

    // Shift register, filled from the low end, frozen outside the slot phase except for two zeros shifted at the end of measurement.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shiftReg <= SHIFT_RESET;
        end else if (ce) begin
            if ((rxState == RX_MEASURE) && lineRise) begin
                shiftReg <= {shiftReg[PACKET_BITS-3:0], 2'b00};
            end else if (decideOne) begin
                shiftReg <= {shiftReg[PACKET_BITS-2:0], 1'b1};
            end else if (decideZero) begin
                shiftReg <= {shiftReg[PACKET_BITS-2:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            serialLineOut <= 1'b0;
        end else if (ce) begin
            serialLineOut <= (rxState == RX_FORWARD) && lineSync;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            grayLatch <= LATCH_RESET;
        end else if (ce) begin
            if (loadLatch) begin
                grayLatch <= shiftReg[23:0];
            end
        end
    end

    assign levelChannelZero = grayLatch[CH0_LSB +: LEVEL_BITS];
    assign levelChannelOne  = grayLatch[CH1_LSB +: LEVEL_BITS];
    assign levelChannelTwo  = grayLatch[CH2_LSB +: LEVEL_BITS];
    assign chLevel[0]       = levelChannelZero;
    assign chLevel[1]       = levelChannelOne;
    assign chLevel[2]       = levelChannelTwo;

    // Divider that stands in for the internal grayscale oscillator.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            divCount <= '0;
        end else if (ce) begin
            if (divCount == DIV_W'(GS_DIVIDE - 1)) begin
                divCount <= '0;
            end else begin
                divCount <= divCount + 1'b1;
            end
        end
    end

    assign gsTick = (divCount == DIV_W'(GS_DIVIDE - 1));

    // Fine count of reference clocks within one grayscale period.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fineCount <= '0;
        end else if (ce) begin
            if (loadLatch) begin
                fineCount <= '0;
            end else if (gsTick) begin
                if (fineCount == FINE_W'(PERIOD_GSCLKS - 1)) begin
                    fineCount <= '0;
                end else begin
                    fineCount <= fineCount + 1'b1;
                end
            end
        end
    end

    // Grayscale counter steps at each gamma turn-off point.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            grayCount <= 8'h00;
        end else if (ce) begin
            if (loadLatch) begin
                grayCount <= 8'h00;
            end else if (gsTick) begin
                if (fineCount == FINE_W'(PERIOD_GSCLKS - 1)) begin
                    grayCount <= 8'h00;
                end else if (fineCount == '0) begin
                    grayCount <= 8'h01;
                end else if ((grayCount != 8'hFF) &&
                             (fineCount + 1'b1 == gammaTurnOff(grayCount))) begin
                    grayCount <= grayCount + 1'b1;
                end
            end
        end
    end

    // Marks that even the full-scale code has reached its turn-off point.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            periodDone <= 1'b0;
        end else if (ce) begin
            if (loadLatch) begin
                periodDone <= 1'b0;
            end else if (gsTick) begin
                if (fineCount == FINE_W'(PERIOD_GSCLKS - 1)) begin
                    periodDone <= 1'b0;
                end else if ((grayCount == 8'hFF) &&
                             (fineCount + 1'b1 == gammaTurnOff(8'hFF))) begin
                    periodDone <= 1'b1;
                end
            end
        end
    end

    generate
        for (genvar ch = 0; ch < 3; ch++) begin : g_channel
            owrpr_channel u_channel (
                .clk        (clk),
                .rst_n      (rst_n),
                .ce         (ce),
                .forceOff   (loadLatch),
                .level      (chLevel[ch]),
                .grayCount  (grayCount),
                .periodDone (periodDone),
                .pwmOut     (pwmOut[ch])
            );
        end
    endgenerate

endmodule : owrpr_top

// *** owrpr_top_chk.sv ***
// Purpose: Concurrent checks on the receiver top-level ports.
// Assumes: The reference clock divider is handed on through the bind.
// Notes:   Pulse widths follow the gamma turn-off counts in system clocks.
`timescale 1ns/10ps
module owrpr_top_chk
    import owrpr_pkg::*;
#(
    parameter int GS_DIVIDE        = GRAYSCALE_REF_CLOCK_DIV,
    parameter int LAT_HOLD_PERIODS = LATCH_HOLD_PERIODS
) (
    input wire logic                  clk,
    input wire logic                  rst_n,
    input wire logic                  serialLineIn,
    input wire logic                  serialLineOut,
    input wire logic [2:0]            pwmOut,
    input wire logic [LEVEL_BITS-1:0] levelChannelZero,
    input wire logic [LEVEL_BITS-1:0] levelChannelOne,
    input wire logic [LEVEL_BITS-1:0] levelChannelTwo
);
    localparam int W1M = GS_DIVIDE - 1;
    localparam int W7M = 13 * GS_DIVIDE - 1;
    logic [15:0] lowRun;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Counts consecutive low samples of the serial pin, saturating.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lowRun <= 16'h0000;
        end else if (serialLineIn) begin
            lowRun <= 16'h0000;
        end else if (lowRun != 16'hFFFF) begin
            lowRun <= lowRun + 16'h0001;
        end
    end

    sequence sCodeOne;
        1'b1 ##W1M pwmOut[0] ##1 !pwmOut[0];
    endsequence
    sequence sCodeSeven;
        (pwmOut[1] throughout (1'b1 ##W7M 1'b1)) ##1 !pwmOut[1];
    endsequence

    chk_zero_level_off: assert property (
        !((levelChannelZero == 8'h00 && pwmOut[0]) || (levelChannelOne == 8'h00 && pwmOut[1])
        || (levelChannelTwo == 8'h00 && pwmOut[2])))
        else $error("output on with zero level");
    chk_load_forces_off: assert property (
        $changed({levelChannelZero, levelChannelOne, levelChannelTwo}) |-> pwmOut == 3'h0)
        else $error("output on at latch load");
    chk_latch_gap_len: assert property (
        $changed({levelChannelZero, levelChannelOne, levelChannelTwo})
        |-> lowRun > 16'(LAT_HOLD_PERIODS * BIT_PERIOD_MIN_CYC))
        else $error("latch load without long low gap");
    chk_fwd_echo: assert property (
        $rose(serialLineOut) |-> $past(serialLineIn, 3))
        else $error("forwarded rise without input rise");
    chk_rise_together: assert property (
        $rose(|pwmOut) |-> pwmOut == {levelChannelTwo != 8'h00, levelChannelOne != 8'h00,
        levelChannelZero != 8'h00})
        else $error("outputs did not turn on together");
    chk_fall_order: assert property (
        $fell(pwmOut[1]) && levelChannelZero <= levelChannelOne |-> !pwmOut[0])
        else $error("lower level outlasted higher level");
    chk_code_one: assert property (
        $rose(pwmOut[0]) && levelChannelZero == 8'h01 |-> sCodeOne)
        else $error("code one on-time wrong");
    chk_code_seven: assert property (
        $rose(pwmOut[1]) && levelChannelOne == 8'h07 |-> sCodeSeven)
        else $error("code seven on-time wrong");
endmodule : owrpr_top_chk

bind owrpr_top owrpr_top_chk #(
    .GS_DIVIDE       (GS_DIVIDE),
    .LAT_HOLD_PERIODS(LAT_HOLD_PERIODS)
) i_owrpr_top_chk (
    .clk             (clk),
    .rst_n           (rst_n),
    .serialLineIn    (serialLineIn),
    .serialLineOut   (serialLineOut),
    .pwmOut          (pwmOut),
    .levelChannelZero(levelChannelZero),
    .levelChannelOne (levelChannelOne),
    .levelChannelTwo (levelChannelTwo)
);

// *** owrpr_host.sv ***
// Purpose: Behavioural host that drives the single-wire line.
// Assumes: Tasks are entered one time unit after a rising clock edge.
// Notes:   The line idles low, as its pull-down would hold it.
`timescale 1ns/10ps
module owrpr_host #(
    parameter int T     = 216,
    parameter int PULSE = 20
) (
    input  wire logic clk,
    output logic      serialLine
);
    initial serialLine = 1'b0;

    task automatic drive(input logic v, input int n);
        serialLine = v;
        repeat (n) @(posedge clk);
        #1;
    endtask : drive

    task automatic slot(input logic b);
        drive(1'b1, PULSE);
        if (b) begin
            drive(1'b0, T / 4 - PULSE);
            drive(1'b1, PULSE);
            drive(1'b0, T - T / 4 - PULSE);
        end else begin
            drive(1'b0, T - PULSE);
        end
    endtask : slot

    task automatic send(input logic [31:0] pkt, input int gapPeriods);
        slot(1'b0);
        for (int i = 29; i >= 0; i--) begin
            slot(pkt[i]);
        end
        drive(1'b0, gapPeriods * T);
    endtask : send
endmodule : owrpr_host

// *** owrpr_top_tb_top.sv ***
// Purpose: Two-device chain bench for the single-wire dimming receiver.
// Assumes: Clock enable stays high; the host keeps one bit period.
// Notes:   On-times are counted in system clocks over one PWM period.
`timescale 1ns/10ps
module owrpr_top_tb_top;
    import owrpr_pkg::*;
    localparam int GSD = 2;
    localparam int PER = PWM_PERIOD_GSCLKS * GSD;

    logic                  clk = 1'b0;
    logic                  rst_n = 1'b0;
    logic                  ce = 1'b1;
    logic                  hostLine;
    logic                  midLine;
    logic [2:0]            pwmA;
    logic [2:0]            pwmB;
    logic [LEVEL_BITS-1:0] lvA [3];
    logic [LEVEL_BITS-1:0] lvB [3];
    int                    failures = 0;
    int                    total_checks = 0;

    always #4 clk = ~clk;

    owrpr_host #(.T(216), .PULSE(20)) i_owrpr_host (.clk(clk), .serialLine(hostLine));

    owrpr_top #(.MAX_PERIOD_CYCLES(256), .GS_DIVIDE(GSD)) i_owrpr_top (
        .clk(clk), .rst_n(rst_n), .ce(ce), .serialLineIn(hostLine), .serialLineOut(midLine),
        .pwmOut(pwmA), .levelChannelZero(lvA[0]), .levelChannelOne(lvA[1]),
        .levelChannelTwo(lvA[2]));

    owrpr_top #(.MAX_PERIOD_CYCLES(256), .GS_DIVIDE(GSD)) i_owrpr_top_b (
        .clk(clk), .rst_n(rst_n), .ce(ce), .serialLineIn(midLine), .serialLineOut(),
        .pwmOut(pwmB), .levelChannelZero(lvB[0]), .levelChannelOne(lvB[1]),
        .levelChannelTwo(lvB[2]));

    task automatic print_verdict;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check

    task automatic check_levels(input int dev, input logic [23:0] exp);
        for (int i = 0; i < 3; i++) begin
            check("level", {8'h00, exp[23-8*i -: 8]}, {8'h00, dev ? lvB[i] : lvA[i]});
        end
    endtask : check_levels

    task automatic pwm_widths(input int e0, input int e1, input int e2);
        int n [3];
        int k;
        n = '{0, 0, 0};
        k = 0;
        while (pwmA === 3'b000) begin
            @(posedge clk);
            #1;
            k++;
            if (k > PER) begin
                failures++;
                $display("CHECK FAILED pwm start expected rise seen none");
                print_verdict();
            end
        end
        for (int c = 0; c < PER; c++) begin
            for (int i = 0; i < 3; i++) begin
                n[i] += (pwmA[i] === 1'b1);
            end
            @(posedge clk);
            #1;
        end
        check("on cycles out0", 16'(e0), 16'(n[0]));
        check("on cycles out1", 16'(e1), 16'(n[1]));
        check("on cycles out2", 16'(e2), 16'(n[2]));
    endtask : pwm_widths

    task automatic s_reset;
        repeat (50) @(posedge clk);
        #1;
        check("pwm idle", 16'h0000, {13'h0000, pwmA});
        check_levels(0, 24'h000000);
        check("forward idle", 16'h0000, {15'h0000, midLine});
    endtask : s_reset

    task automatic s_chain;
        i_owrpr_host.send(32'h3A00801F, 4);
        check_levels(0, 24'h000000);
        i_owrpr_host.send(32'h3A2107FE, 9);
        check_levels(0, 24'h00801F);
        check_levels(1, 24'h2107FE);
        pwm_widths(0, (886 - 1) * GSD, (110 - 1) * GSD);
    endtask : s_chain

    task automatic s_bad;
        i_owrpr_host.send(32'h3B112233, 9);
        check_levels(0, 24'h00801F);
        check_levels(1, 24'h2107FE);
    endtask : s_bad

    task automatic s_gamma;
        i_owrpr_host.send(32'h3A0107FF, 9);
        check_levels(0, 24'h0107FF);
        pwm_widths((2 - 1) * GSD, (14 - 1) * GSD, (1902 - 1) * GSD);
    endtask : s_gamma

    initial begin
        repeat (4) @(posedge clk);
        #1;
        rst_n = 1'b1;
        s_reset();
        s_chain();
        s_bad();
        s_gamma();
        print_verdict();
    end
endmodule : owrpr_top_tb_top
